// ===== rtl/tuner_config_register_map.sv
// Register bank of the tuner with its 2-wire serial slave on the bus clock.
`timescale 1ns/10ps
// Functional notes
// - Twelve writable byte registers followed by two read-only status bytes.
// - Address select pin left open counts as logic low.
// - Divide word bits 14..8 in offset 0 low seven bits, bits 7..0 in offset 1.
// - Status one: power-on bit 7, autoselect active 6, autoselect end 5, lock 4.
// - Status two: selected oscillator index in bits 7..3, tune code in 2..0.
// - Control: standby bit 7, factory power bit 5, baseband gain 3..0.
// - Shutdown register holds per-block off bits 6..0, bit 7 ignored.
// - Oscillator register: index 7..3, autoselect 2, latch 1, read enable 0.
// - Dividers register: crystal output divider 7..5, reference divider 4..0.
// - Synth register: post-divide 7, pump source 6, pump level 5, rest ignored.
// - Offsets 3 and 4 are unused and every bit written there is ignored.
// - Test register: pump test 7..5, fast bit 3, lock mux 2..0, bit 4 ignored.
// - Filter register holds the eight-bit lowpass corner code.
// - Standby turns off signal path and synthesizer, keeps bus and crystal buffer.
module tuner_config_register_map
    import tuner_pkg::*;
#(
    parameter logic [6:0] BUS_ADDR_HIGH = 7'h60,
    parameter logic [6:0] BUS_ADDR_LOW = 7'h61
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic scl_clk,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_low,
    input wire status_in_t status_in,
    output tuner_cfg_t cfg,
    output block_en_t block_en
);

    // ==========================================================================
    // Link side state, clocked by the bus clock.
    typedef struct packed {
        link_state_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [3:0] ptr;
        logic ack_ok;
        logic rw;
        logic start_seen;
        logic wr_tgl;
        logic por_clr_tgl;
        logic addr_low_m;
        logic addr_low_q;
        logic [11:0][7:0] regs;
    } link_t;

    // ==========================================================================
    // System side state, clocked by sys_clk.
    typedef struct packed {
        logic wr_m;
        logic wr_q;
        logic wr_d;
        logic por_m;
        logic por_q;
        logic por_d;
        logic sta_m;
        logic sta_q;
        logic sta_d;
        logic sto_m;
        logic sto_q;
        logic sto_d;
        logic busy;
        status_in_t st_m;
        status_in_t st_q;
        logic power_on_flag;
        logic [15:0] stat_hold;
        tuner_cfg_t cfg;
        block_en_t en;
    } sys_t;

    link_t link_r;
    link_t link_nxt;
    sys_t sys_r;
    sys_t sys_nxt;
    logic start_tgl_r;
    logic stop_tgl_r;
    logic sda_oe_r;
    logic drive_low;
    logic [6:0] own_addr;

    // ==========================================================================
    // Register image to configuration fields; ignored bits read as zero.
    function automatic tuner_cfg_t decode_regs(input logic [11:0][7:0] regs);
        tuner_cfg_t c;
        c = '0;
        c.int_divide = {regs[REG_DIV_HIGH][6:0], regs[REG_DIV_LOW]};
        c.pump = pump_reg_t'(regs[REG_PUMP]);
        c.pump.ignored = 4'h0;
        c.dividers = dividers_reg_t'(regs[REG_DIVIDERS]);
        c.synth = synth_reg_t'(regs[REG_SYNTH]);
        c.synth.ignored = 5'h00;
        c.osc = osc_reg_t'(regs[REG_OSC]);
        c.filter_corner_code = regs[REG_FILTER];
        c.control = control_reg_t'(regs[REG_CONTROL]);
        c.control.ignored_hi = 1'b0;
        c.control.ignored_lo = 1'b0;
        c.power_down = power_down_reg_t'(regs[REG_POWER_DOWN]);
        c.power_down.ignored = 1'b0;
        c.test = test_reg_t'(regs[REG_TEST]);
        c.test.ignored = 1'b0;
        return c;
    endfunction

    // ==========================================================================
    // Start and stop detection on data edges while the bus clock is high.
    always_ff @(negedge sda_in or posedge reset)
    begin
        if (reset)
        begin
            start_tgl_r <= 1'b0;
        end
        else if (scl_clk)
        begin
            start_tgl_r <= ~start_tgl_r;
        end
    end

    always_ff @(posedge sda_in or posedge reset)
    begin
        if (reset)
        begin
            stop_tgl_r <= 1'b0;
        end
        else if (scl_clk)
        begin
            stop_tgl_r <= ~stop_tgl_r;
        end
    end

    // ==========================================================================
    // Serial slave: address, register pointer, write data and read data bytes.
    always_comb
    begin
        link_nxt = link_r;
        link_nxt.addr_low_m = addr_low;
        link_nxt.addr_low_q = link_r.addr_low_m;
        link_nxt.sh = {link_r.sh[6:0], sda_in};
        link_nxt.cnt = (link_r.cnt == 4'd8) ? 4'd0 : link_r.cnt + 4'd1;
        own_addr = link_r.addr_low_q ? BUS_ADDR_LOW : BUS_ADDR_HIGH;
        if (start_tgl_r != link_r.start_seen)
        begin
            link_nxt.start_seen = start_tgl_r;
            link_nxt.st = LINK_ADDR;
            link_nxt.cnt = 4'd1;
        end
        else
        begin
            case (link_r.st)
                LINK_ADDR:
                begin
                    if (link_r.cnt == 4'd7)
                    begin
                        link_nxt.ack_ok = (link_r.sh[6:0] == own_addr);
                        link_nxt.rw = sda_in;
                    end
                    else if (link_r.cnt == 4'd8)
                    begin
                        if (!link_r.ack_ok)
                        begin
                            link_nxt.st = LINK_IDLE;
                        end
                        else if (link_r.rw)
                        begin
                            link_nxt.st = LINK_RDATA;
                        end
                        else
                        begin
                            link_nxt.st = LINK_REG;
                        end
                    end
                end
                LINK_REG:
                begin
                    if (link_r.cnt == 4'd7)
                    begin
                        link_nxt.ptr = {link_r.sh[2:0], sda_in};
                    end
                    else if (link_r.cnt == 4'd8)
                    begin
                        link_nxt.st = LINK_WDATA;
                    end
                end
                LINK_WDATA:
                begin
                    if (link_r.cnt == 4'd7)
                    begin
                        if (link_r.ptr < NUM_WRITE_REGS)
                        begin
                            link_nxt.regs[link_r.ptr] = {link_r.sh[6:0], sda_in};
                            link_nxt.wr_tgl = ~link_r.wr_tgl;
                        end
                    end
                    else if (link_r.cnt == 4'd8)
                    begin
                        link_nxt.ptr = link_r.ptr + 4'd1;
                    end
                end
                LINK_RDATA:
                begin
                    if (link_r.cnt == 4'd8 && sda_in)
                    begin
                        link_nxt.st = LINK_IDLE;
                    end
                end
                default:
                begin
                    link_nxt.st = LINK_IDLE;
                end
            endcase
            if (link_nxt.st == LINK_RDATA && link_nxt.cnt == 4'd0)
            begin
                if (link_r.ptr == REG_STATUS_ONE)
                begin
                    link_nxt.tx = sys_r.stat_hold[15:8];
                    link_nxt.por_clr_tgl = ~link_r.por_clr_tgl;
                end
                else if (link_r.ptr == REG_STATUS_TWO)
                begin
                    link_nxt.tx = sys_r.stat_hold[7:0];
                end
                else
                begin
                    link_nxt.tx = READ_UNDEF;
                end
                link_nxt.ptr = link_r.ptr + 4'd1;
            end
        end
    end

    always_ff @(posedge scl_clk or posedge reset)
    begin
        if (reset)
        begin
            link_r <= '0;
            link_r.regs <= RESET_REGS;
        end
        else
        begin
            link_r <= link_nxt;
        end
    end

    // ==========================================================================
    // Data line drive, changed on the falling bus clock edge.
    always_comb
    begin
        drive_low = 1'b0;
        if (link_r.st == LINK_RDATA)
        begin
            drive_low = (link_r.cnt < 4'd8) && !link_r.tx[3'(4'd7 - link_r.cnt)];
        end
        else if (link_r.st != LINK_IDLE)
        begin
            drive_low = (link_r.cnt == 4'd8) && link_r.ack_ok;
        end
    end

    always_ff @(negedge scl_clk or posedge reset)
    begin
        if (reset)
        begin
            sda_oe_r <= 1'b0;
        end
        else
        begin
            sda_oe_r <= drive_low;
        end
    end

    assign sda_oe = sda_oe_r;
    assign sda_out = 1'b0;

    // ==========================================================================
    // System side: crossings, configuration copy, status capture and enables.
    always_comb
    begin
        sys_nxt = sys_r;
        sys_nxt.wr_m = link_r.wr_tgl;
        sys_nxt.wr_q = sys_r.wr_m;
        sys_nxt.wr_d = sys_r.wr_q;
        sys_nxt.por_m = link_r.por_clr_tgl;
        sys_nxt.por_q = sys_r.por_m;
        sys_nxt.por_d = sys_r.por_q;
        sys_nxt.sta_m = start_tgl_r;
        sys_nxt.sta_q = sys_r.sta_m;
        sys_nxt.sta_d = sys_r.sta_q;
        sys_nxt.sto_m = stop_tgl_r;
        sys_nxt.sto_q = sys_r.sto_m;
        sys_nxt.sto_d = sys_r.sto_q;
        sys_nxt.st_m = status_in;
        sys_nxt.st_q = sys_r.st_m;
        if (sys_r.sta_q != sys_r.sta_d)
        begin
            sys_nxt.busy = 1'b1;
        end
        else if (sys_r.sto_q != sys_r.sto_d)
        begin
            sys_nxt.busy = 1'b0;
        end
        if (sys_r.wr_q != sys_r.wr_d)
        begin
            sys_nxt.cfg = decode_regs(link_r.regs);
        end
        if (sys_r.por_q != sys_r.por_d)
        begin
            sys_nxt.power_on_flag = 1'b0;
        end
        if (!sys_r.busy)
        begin
            sys_nxt.stat_hold = {sys_r.power_on_flag, sys_r.st_q.autoselect_active, sys_r.st_q.autoselect_end,
                sys_r.st_q.lock_flag, 4'h0, sys_r.st_q.selected_osc_index, sys_r.st_q.tune_code};
        end
        sys_nxt.en.synth_on = !sys_r.cfg.control.standby_bit && !sys_r.cfg.power_down.synth_off;
        sys_nxt.en.divider_on = !sys_r.cfg.control.standby_bit && !sys_r.cfg.power_down.divider_off;
        sys_nxt.en.osc_on = !sys_r.cfg.control.standby_bit && !sys_r.cfg.power_down.osc_off;
        sys_nxt.en.baseband_on = !sys_r.cfg.control.standby_bit && !sys_r.cfg.power_down.baseband_off;
        sys_nxt.en.mixer_on = !sys_r.cfg.control.standby_bit && !sys_r.cfg.power_down.mixer_off;
        sys_nxt.en.rf_amp_on = !sys_r.cfg.control.standby_bit && !sys_r.cfg.power_down.rf_amp_off;
        sys_nxt.en.front_end_on = !sys_r.cfg.control.standby_bit && !sys_r.cfg.power_down.front_end_off;
        sys_nxt.en.xtal_buf_on = 1'b1;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sys_r <= '0;
            sys_r.power_on_flag <= 1'b1;
            sys_r.cfg <= decode_regs(RESET_REGS);
            sys_r.en <= 8'hFF;
        end
        else
        begin
            sys_r <= sys_nxt;
        end
    end

    assign cfg = sys_r.cfg;
    assign block_en = sys_r.en;

    // ==========================================================================
    // Checks.
    a_divide_word_copy: assert property (@(posedge sys_clk) disable iff (reset)
        (sys_r.wr_q != sys_r.wr_d) |=> cfg.int_divide == $past({link_r.regs[0][6:0], link_r.regs[1]}))
        else $error("Divide word not copied from offsets 0 and 1.");
    a_osc_fields_copy: assert property (@(posedge sys_clk) disable iff (reset)
        (sys_r.wr_q != sys_r.wr_d) |=> cfg.osc == $past(link_r.regs[7]))
        else $error("Oscillator fields not copied from offset 7.");
    a_control_ignored_zero: assert property (@(posedge sys_clk) disable iff (reset)
        (sys_r.wr_q != sys_r.wr_d) |=> !cfg.control.ignored_hi && !cfg.control.ignored_lo
        && cfg.control.baseband_gain == $past(link_r.regs[9][3:0]))
        else $error("Control register layout wrong.");
    a_standby_gates_path: assert property (@(posedge sys_clk) disable iff (reset)
        cfg.control.standby_bit [*2] |-> !block_en.synth_on && !block_en.mixer_on && !block_en.front_end_on
        && block_en.xtal_buf_on)
        else $error("Standby did not gate the signal path.");
    a_shutdown_mixer_bit: assert property (@(posedge sys_clk) disable iff (reset)
        !cfg.control.standby_bit && cfg.power_down.mixer_off && !cfg.power_down.rf_amp_off
        |=> !block_en.mixer_on && block_en.rf_amp_on)
        else $error("Shutdown bits not applied per block.");
    a_status_one_layout: assert property (@(posedge sys_clk) disable iff (reset)
        !sys_r.busy |=> sys_r.stat_hold[15:12] == $past({sys_r.power_on_flag, sys_r.st_q.autoselect_active,
        sys_r.st_q.autoselect_end, sys_r.st_q.lock_flag}))
        else $error("Status one layout wrong.");
    a_status_two_layout: assert property (@(posedge sys_clk) disable iff (reset)
        !sys_r.busy |=> sys_r.stat_hold[7:0] == $past({sys_r.st_q.selected_osc_index, sys_r.st_q.tune_code}))
        else $error("Status two layout wrong.");
    a_por_read_clears: assert property (@(posedge sys_clk) disable iff (reset)
        $changed(sys_r.por_q) |=> !sys_r.power_on_flag)
        else $error("Power-on flag not cleared after a status read.");
    a_unmapped_write_kept: assert property (@(posedge scl_clk) disable iff (reset)
        link_r.st == LINK_WDATA && link_r.cnt == 4'd7 && link_r.ptr >= NUM_WRITE_REGS
        && start_tgl_r == link_r.start_seen |=> link_r.regs == $past(link_r.regs) && link_r.wr_tgl == $past(link_r.wr_tgl))
        else $error("Write beyond the writable registers changed state.");
    a_write_only_reads: assert property (@(posedge scl_clk) disable iff (reset)
        link_nxt.st == LINK_RDATA && link_nxt.cnt == 4'd0 && link_r.ptr < REG_STATUS_ONE
        && start_tgl_r == link_r.start_seen |=> link_r.tx == READ_UNDEF)
        else $error("Write-only offset read returned defined data.");
    a_addr_select_ack: assert property (@(posedge scl_clk) disable iff (reset)
        link_r.st == LINK_ADDR && link_r.cnt == 4'd7 && start_tgl_r == link_r.start_seen && !link_r.addr_low_q
        && link_r.sh[6:0] == BUS_ADDR_HIGH |=> link_r.ack_ok)
        else $error("Open address pin did not select the high address.");

endmodule

// ===== rtl/tuner_pkg.sv
// Package with register offsets, reset values, field layouts and link states of the tuner register bank.
package tuner_pkg;

    // ==========================================================================
    // Register offsets.
    localparam logic [3:0] REG_DIV_HIGH = 4'h0;
    localparam logic [3:0] REG_DIV_LOW = 4'h1;
    localparam logic [3:0] REG_PUMP = 4'h2;
    localparam logic [3:0] REG_UNUSED_A = 4'h3;
    localparam logic [3:0] REG_UNUSED_B = 4'h4;
    localparam logic [3:0] REG_DIVIDERS = 4'h5;
    localparam logic [3:0] REG_SYNTH = 4'h6;
    localparam logic [3:0] REG_OSC = 4'h7;
    localparam logic [3:0] REG_FILTER = 4'h8;
    localparam logic [3:0] REG_CONTROL = 4'h9;
    localparam logic [3:0] REG_POWER_DOWN = 4'hA;
    localparam logic [3:0] REG_TEST = 4'hB;
    localparam logic [3:0] REG_STATUS_ONE = 4'hC;
    localparam logic [3:0] REG_STATUS_TWO = 4'hD;
    localparam logic [3:0] NUM_WRITE_REGS = 4'hC;

    // ==========================================================================
    // Reset values and read filler.
    localparam logic [7:0] RST_DIV_HIGH = 8'h03;
    localparam logic [7:0] RST_DIV_LOW = 8'hB6;
    localparam logic [7:0] RST_PUMP = 8'h00;
    localparam logic [7:0] RST_UNUSED = 8'h00;
    localparam logic [7:0] RST_DIVIDERS = 8'h04;
    localparam logic [7:0] RST_SYNTH = 8'hC0;
    localparam logic [7:0] RST_OSC = 8'hCC;
    localparam logic [7:0] RST_FILTER = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_POWER_DOWN = 8'h00;
    localparam logic [7:0] RST_TEST = 8'h08;
    localparam logic [7:0] READ_UNDEF = 8'hFF;
    localparam logic [11:0][7:0] RESET_REGS = {RST_TEST, RST_POWER_DOWN, RST_CONTROL, RST_FILTER, RST_OSC,
        RST_SYNTH, RST_DIVIDERS, RST_UNUSED, RST_UNUSED, RST_PUMP, RST_DIV_LOW, RST_DIV_HIGH};

    // ==========================================================================
    // Host power-up wait before the first write.
    localparam int POWER_UP_WAIT_US = 100;
    localparam int SYS_CLK_MHZ = 100;
    localparam int POWER_UP_WAIT_CYCLES = POWER_UP_WAIT_US * SYS_CLK_MHZ;

    // ==========================================================================
    // Field layouts, most significant bit first.
    typedef struct packed {
        logic [1:0] pump_min_pulse;
        logic [1:0] pump_linearity;
        logic [3:0] ignored;
    } pump_reg_t;

    typedef struct packed {
        logic [2:0] crystal_out_divider;
        logic [4:0] ref_divider;
    } dividers_reg_t;

    typedef struct packed {
        logic osc_post_divide;
        logic pump_current_source;
        logic pump_current_level;
        logic [4:0] ignored;
    } synth_reg_t;

    typedef struct packed {
        logic [4:0] oscillator_index;
        logic auto_osc_select_en;
        logic tune_code_latch;
        logic tune_code_read_en;
    } osc_reg_t;

    typedef struct packed {
        logic standby_bit;
        logic ignored_hi;
        logic factory_power_bit;
        logic ignored_lo;
        logic [3:0] baseband_gain;
    } control_reg_t;

    typedef struct packed {
        logic ignored;
        logic synth_off;
        logic divider_off;
        logic osc_off;
        logic baseband_off;
        logic mixer_off;
        logic rf_amp_off;
        logic front_end_off;
    } power_down_reg_t;

    typedef struct packed {
        logic [2:0] pump_test_select;
        logic ignored;
        logic fast_bit;
        logic [2:0] lock_output_select;
    } test_reg_t;

    typedef struct packed {
        logic [14:0] int_divide;
        pump_reg_t pump;
        dividers_reg_t dividers;
        synth_reg_t synth;
        osc_reg_t osc;
        logic [7:0] filter_corner_code;
        control_reg_t control;
        power_down_reg_t power_down;
        test_reg_t test;
    } tuner_cfg_t;

    typedef struct packed {
        logic autoselect_active;
        logic autoselect_end;
        logic lock_flag;
        logic [4:0] selected_osc_index;
        logic [2:0] tune_code;
    } status_in_t;

    typedef struct packed {
        logic synth_on;
        logic divider_on;
        logic osc_on;
        logic baseband_on;
        logic mixer_on;
        logic rf_amp_on;
        logic front_end_on;
        logic xtal_buf_on;
    } block_en_t;

    typedef enum logic [2:0] {
        LINK_IDLE = 3'b000,
        LINK_ADDR = 3'b001,
        LINK_REG = 3'b011,
        LINK_WDATA = 3'b010,
        LINK_RDATA = 3'b110
    } link_state_t;

endpackage

// ===== test/host_model.sv
// Host controller model that drives the 2-wire bus of the tuner.
`timescale 1ns/10ps
module host_model
(
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ==========================================================================
    // The bus clock stands high between frames and runs at 6 ns inside them.
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic put_bit(input logic b);
        #1 sda_low = ~b;
        #2 scl = 1'b1;
        #3 scl = 1'b0;
    endtask
    task automatic get_bit(output logic b);
        #1 sda_low = 1'b0;
        #2 scl = 1'b1;
        b = sda;
        #3 scl = 1'b0;
    endtask
    task automatic start();
        #1 sda_low = 1'b0;
        #2 scl = 1'b1;
        #3 sda_low = 1'b1;
        #3 scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i]);
        get_bit(b);
        ack = ~b;
    endtask
    // ==========================================================================
    // One register access: pointer write, then a data byte or a repeated start and one read byte.
    task automatic access(input logic [6:0] dev, input logic [3:0] ofs, input logic rd, input logic [7:0] wd,
        output logic ack, output logic [7:0] rdata);
        logic a2;
        start();
        send({dev, 1'b0}, ack);
        send({4'h0, ofs}, a2);
        if (rd)
        begin
            start();
            send({dev, 1'b1}, a2);
            for (int i = 7; i >= 0; i--)
                get_bit(rdata[i]);
            put_bit(1'b1);
        end
        else
            send(wd, a2);
        #1 sda_low = 1'b1;
        #2 scl = 1'b1;
        #3 sda_low = 1'b0;
    endtask
endmodule

// ===== test/tb.sv
// Testbench of the tuner register bank driven through a host model.
`timescale 1ns/10ps
module tb;
    import tuner_pkg::*;
    typedef struct packed {logic [3:0] ofs; logic [7:0] data; logic [7:0] exp;} row_t;
    localparam row_t ROWS [10] = '{{4'h1, 8'h7F, 8'h7F}, {4'h0, 8'h88, 8'h08}, {4'h2, 8'h0F, 8'h00},
        {4'h5, 8'h5A, 8'h5A}, {4'h6, 8'h7F, 8'h60}, {4'h7, 8'h53, 8'h53}, {4'h8, 8'hA5, 8'hA5},
        {4'h9, 8'h5B, 8'h0B}, {4'hA, 8'hD5, 8'h55}, {4'hB, 8'hB8, 8'hA8}};
    localparam tuner_cfg_t EXP_CFG = {15'h087F, 64'h005A6053A50B55A8};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic addr_low = 1'b0;
    status_in_t status_in = '0;
    logic scl_clk, sda_low, sda_out, sda_oe;
    logic [7:0] rd;
    tuner_cfg_t cfg;
    block_en_t block_en;
    int err_count = 0;
    int check_count = 0;
    wire sda = ~((sda_oe & ~sda_out) | sda_low);
    always #5 sys_clk = ~sys_clk;
    tuner_config_register_map tuner_config_register_map_inst (.sys_clk(sys_clk), .reset(reset),
        .scl_clk(scl_clk), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_low(addr_low),
        .status_in(status_in), .cfg(cfg), .block_en(block_en));
    host_model host_model_inst (.sda(sda), .scl(scl_clk), .sda_low(sda_low));
    // ==========================================================================
    // Comparison, bus transfer and closing helpers.
    task automatic check(input logic [78:0] seen, input logic [78:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic [6:0] dev, input logic [3:0] ofs, input logic rdn, input logic [7:0] wd,
        input logic exp_ack);
        logic ack;
        host_model_inst.access(dev, ofs, rdn, wd, ack, rd);
        repeat (8) @(posedge sys_clk);
        #1;
        check(ack, exp_ack);
    endtask
    function automatic logic [7:0] view(input logic [3:0] ofs);
        case (ofs)
            REG_DIV_HIGH: view = {1'b0, cfg.int_divide[14:8]};
            REG_DIV_LOW: view = cfg.int_divide[7:0];
            REG_PUMP: view = cfg.pump;
            REG_DIVIDERS: view = cfg.dividers;
            REG_SYNTH: view = cfg.synth;
            REG_OSC: view = cfg.osc;
            REG_FILTER: view = cfg.filter_corner_code;
            REG_CONTROL: view = cfg.control;
            REG_POWER_DOWN: view = cfg.power_down;
            default: view = cfg.test;
        endcase
    endfunction
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================================
    // Main sequence: reset values, row table, then hand-written cases.
    initial
    begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        check(cfg.int_divide, 15'd950);
        check(block_en, 8'hFF);
        repeat (POWER_UP_WAIT_CYCLES) @(posedge sys_clk);
        foreach (ROWS[i])
        begin
            xfer(7'h60, ROWS[i].ofs, 1'b0, ROWS[i].data, 1'b1);
            check(view(ROWS[i].ofs), ROWS[i].exp);
        end
        check(block_en, 8'h55);
        xfer(7'h60, REG_UNUSED_A, 1'b0, 8'hFF, 1'b1);
        xfer(7'h60, REG_UNUSED_B, 1'b0, 8'hFF, 1'b1);
        check(cfg, EXP_CFG);
        xfer(7'h60, 4'hE, 1'b0, 8'h5A, 1'b1);
        check(cfg, EXP_CFG);
        xfer(7'h60, REG_CONTROL, 1'b0, 8'h80, 1'b1);
        check(block_en, 8'h01);
        @(posedge sys_clk);
        status_in <= {1'b1, 1'b0, 1'b1, 5'h13, 3'h6};
        repeat (4) @(posedge sys_clk);
        xfer(7'h60, REG_STATUS_ONE, 1'b1, 8'h00, 1'b1);
        check(rd, 8'hD0);
        xfer(7'h60, REG_STATUS_ONE, 1'b1, 8'h00, 1'b1);
        check(rd, 8'h50);
        xfer(7'h60, REG_STATUS_TWO, 1'b1, 8'h00, 1'b1);
        check(rd, 8'h9E);
        xfer(7'h60, REG_DIVIDERS, 1'b1, 8'h00, 1'b1);
        check(rd, READ_UNDEF);
        xfer(7'h61, REG_FILTER, 1'b0, 8'h3C, 1'b0);
        check(cfg.filter_corner_code, 8'hA5);
        @(posedge sys_clk);
        addr_low <= 1'b1;
        repeat (4) @(posedge sys_clk);
        xfer(7'h61, REG_FILTER, 1'b0, 8'h3C, 1'b1);
        check(cfg.filter_corner_code, 8'h3C);
        xfer(7'h60, REG_FILTER, 1'b0, 8'h11, 1'b0);
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        check(cfg.int_divide, 15'd950);
        check(cfg.filter_corner_code, RST_FILTER);
        check(block_en, 8'hFF);
        xfer(7'h61, REG_STATUS_ONE, 1'b1, 8'h00, 1'b1);
        check(rd, 8'hD0);
        results();
    end
    initial
    begin
        #400000;
        err_count++;
        results();
    end
endmodule
